/* File: hdl/tps_consts.svh */
// constants for the tape punch source sequencer
// assumes a 100 MHz single clock domain
`ifndef TPS_CONSTS_SVH
`define TPS_CONSTS_SVH

`define TPS_CLK_HZ 100000000
`define TPS_CLK_PERIOD_NS 10
`define TPS_LEVELS 8
`define TPS_FIFO_DEPTH 16
`define TPS_CNT_W 21
`define TPS_FEED_HZ 105
`define TPS_FAST_HZ 240
`define TPS_STAGE1_US 10000
`define TPS_STAGE2_US 10000
`define TPS_DRIVE_NS 2000
`define TPS_FEED_CYC (`TPS_CLK_HZ / `TPS_FEED_HZ)
`define TPS_FAST_CYC (`TPS_CLK_HZ / `TPS_FAST_HZ)
`define TPS_STAGE1_CYC (`TPS_STAGE1_US * (`TPS_CLK_HZ / 1000000))
`define TPS_STAGE2_CYC (`TPS_STAGE2_US * (`TPS_CLK_HZ / 1000000))
`define TPS_DRIVE_CYC ((`TPS_DRIVE_NS + `TPS_CLK_PERIOD_NS - 1) / `TPS_CLK_PERIOD_NS)
`define TPS_DELETE_CHAR 8'hFF
`define TPS_BLANK_CHAR 8'h00
`define TPS_SW_BLANK 0
`define TPS_SW_CHAR 1
`define TPS_SW_FAST 2
`define TPS_NUM_SW 3

`endif

/* File: hdl/tps_pkg.sv */
// types shared by the tape punch source sequencer
// assumes tps_consts.svh is on the include path
`include "tps_consts.svh"

package tps_pkg;
   typedef logic [`TPS_LEVELS-1:0] tps_char_t;
   typedef logic [`TPS_CNT_W-1:0] tps_cnt_t;

   typedef struct packed {
      logic serial;
      logic parallel;
      logic blank_feed;
      logic char_feed;
   } tps_sel_s;

   typedef struct packed {
      logic supply_exhausted;
      logic low_tape;
      logic chad_full;
      logic tape_absent;
      logic tight_tape;
   } tps_sense_s;

   typedef enum logic [1:0] {PWR_WAIT1, PWR_WAIT2, PWR_READY} tps_pwr_e;
   typedef enum logic {DRV_IDLE, DRV_HOLD} tps_drv_e;
endpackage

/* File: hdl/tps_sequencer.sv */
// punch source sequencer: priming, punch commands, power-up delete, alarms
// assumes all pin inputs are asynchronous to mclk_i and switches are two-contact
//
// Function
// - serial and parallel selects never both active once ready
// - serial source: spacing bit inhibits, marking punches
// - parallel source: level primed from auxiliary bit
// - before ready: feeds off, sources on, no inhibit
// - power-ready delayed through two ordered stages
// - ready asserts: punch one all-holes delete character
// - delete priming captured, immune to select changes
// - feed switches debounced by set/reset latch
// - held feed switch runs 105 Hz oscillator
// - held feed switch asserts matching feed select
// - character feed removes both source selects
// - one punch command per feed oscillator pulse
// - toggle runs 240 Hz oscillator, punches per pulse
// - auxiliary sample rise selects parallel source
// - auxiliary sample fall punches auxiliary character
// - serial sample pulse selects serial source
// - end of serial sample punches primed character
// - supply exhausted stops the sending equipment
// - low tape, chad bin only light indicators
// - tape-absent and tight-tape accepted as alarms
// - all eight levels primed identically
// - first timing pulse clears set level drivers
`timescale 1ns/100ps
`default_nettype none

`include "tps_consts.svh"

module tps_fifo #(
   parameter int WIDTH = `TPS_LEVELS,
   parameter int DEPTH = `TPS_FIFO_DEPTH
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic full, empty, do_wr, do_rd;

   always_comb begin
      empty = (wr_ptr == rd_ptr);
      full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
      do_wr = in_valid_i && !full;
      do_rd = out_ready_i && !empty;
      next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
   end

   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end
endmodule

module tps_sequencer #(
   parameter int STAGE1_CYC = `TPS_STAGE1_CYC,
   parameter int STAGE2_CYC = `TPS_STAGE2_CYC,
   parameter int FEED_CYC = `TPS_FEED_CYC,
   parameter int FAST_CYC = `TPS_FAST_CYC
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // data from sending equipment and converter
   input wire tps_pkg::tps_char_t aux_bits_i,
   input wire logic aux_sample_i,
   input wire tps_pkg::tps_char_t serial_bits_i,
   input wire logic serial_sample_i,
   // panel: programmed character and switch contacts
   input wire tps_pkg::tps_char_t prog_char_i,
   input wire logic [`TPS_NUM_SW-1:0] sw_make_i,
   input wire logic [`TPS_NUM_SW-1:0] sw_break_i,
   // tape and chad sensors
   input wire tps_pkg::tps_sense_s sense_i,
   // punch drive
   output tps_pkg::tps_char_t level_drive_o,
   output logic feed_drive_o,
   output logic punch_cmd_o,
   // status
   output tps_pkg::tps_sel_s sel_o,
   output logic power_ready_o,
   output logic hold_off_o,
   // alarms and indicators
   output logic stop_sending_o,
   output logic low_tape_lamp_o,
   output logic chad_full_lamp_o,
   output logic tape_absent_alarm_o,
   output logic tight_tape_alarm_o
);
   import tps_pkg::*;

   localparam int SYNC_W = 3 * `TPS_LEVELS + 2 + 2 * `TPS_NUM_SW + 5;
   localparam tps_cnt_t DRIVE_CYC = tps_cnt_t'(`TPS_DRIVE_CYC);
   localparam tps_char_t BLANK_CHAR = `TPS_BLANK_CHAR;

   // two-flop synchronisers for every pin
   logic [SYNC_W-1:0] sync1, sync2;
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {aux_bits_i, aux_sample_i, serial_bits_i, serial_sample_i, prog_char_i,
                   sw_make_i, sw_break_i, sense_i};
         sync2 <= sync1;
      end
   end

   tps_char_t aux_s, ser_s, prog_s;
   logic aux_smp_s, ser_smp_s;
   logic [`TPS_NUM_SW-1:0] make_s, break_s;
   tps_sense_s sense_s;
   assign {aux_s, aux_smp_s, ser_s, ser_smp_s, prog_s, make_s, break_s, sense_s} = sync2;

   // power-ready sequence
   tps_pwr_e pwr, next_pwr;
   tps_cnt_t pwr_cnt, next_pwr_cnt;
   logic del_req, next_del_req;

   always_comb begin
      next_pwr = pwr;
      next_pwr_cnt = pwr_cnt + 1'b1;
      next_del_req = 1'b0;
      case (pwr)
         PWR_WAIT1: begin
            if (pwr_cnt >= tps_cnt_t'(STAGE1_CYC - 1)) begin
               next_pwr = PWR_WAIT2;
               next_pwr_cnt = '0;
            end
         end
         PWR_WAIT2: begin
            if (pwr_cnt >= tps_cnt_t'(STAGE2_CYC - 1)) begin
               next_pwr = PWR_READY;
               next_pwr_cnt = '0;
               next_del_req = 1'b1;
            end
         end
         PWR_READY: begin
            next_pwr_cnt = '0;
         end
         default: begin
            next_pwr = PWR_WAIT1;
            next_pwr_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pwr <= PWR_WAIT1;
         pwr_cnt <= '0;
         del_req <= 1'b0;
      end else begin
         pwr <= next_pwr;
         pwr_cnt <= next_pwr_cnt;
         del_req <= next_del_req;
      end
   end

   logic ready;
   assign ready = (pwr == PWR_READY);

   // switch latches, sample edges and mode flag
   logic [`TPS_NUM_SW-1:0] sw_latch, next_sw_latch;
   logic aux_smp_d, ser_smp_d, mode_par, next_mode_par;
   logic aux_rise, aux_fall, ser_rise, ser_fall;

   for (genvar s = 0; s < `TPS_NUM_SW; s++) begin : g_sw
      always_comb begin
         // set on make contact, reset only on break contact
         if (make_s[s]) begin
            next_sw_latch[s] = 1'b1;
         end else if (break_s[s]) begin
            next_sw_latch[s] = 1'b0;
         end else begin
            next_sw_latch[s] = sw_latch[s];
         end
      end
   end

   always_comb begin
      aux_rise = aux_smp_s && !aux_smp_d;
      aux_fall = !aux_smp_s && aux_smp_d;
      ser_rise = ser_smp_s && !ser_smp_d;
      ser_fall = !ser_smp_s && ser_smp_d;
      next_mode_par = mode_par;
      if (aux_rise) begin
         next_mode_par = 1'b1;
      end else if (ser_rise) begin
         next_mode_par = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sw_latch <= '0;
         aux_smp_d <= 1'b0;
         ser_smp_d <= 1'b0;
         mode_par <= 1'b0;
      end else begin
         sw_latch <= next_sw_latch;
         aux_smp_d <= aux_smp_s;
         ser_smp_d <= ser_smp_s;
         mode_par <= next_mode_par;
      end
   end

   // source selects and per-level priming
   tps_sel_s sel;
   tps_char_t prime;

   always_comb begin
      if (!ready) begin
         sel = '{serial: 1'b1, parallel: 1'b1, blank_feed: 1'b0, char_feed: 1'b0};
      end else begin
         sel.blank_feed = sw_latch[`TPS_SW_BLANK];
         sel.char_feed = sw_latch[`TPS_SW_CHAR] || sw_latch[`TPS_SW_FAST];
         sel.parallel = mode_par && !sel.char_feed;
         sel.serial = !mode_par && !sel.char_feed;
      end
   end

   for (genvar l = 0; l < `TPS_LEVELS; l++) begin : g_level
      always_comb begin
         if (sel.serial && sel.parallel) begin
            prime[l] = 1'b1;
         end else if (sel.blank_feed) begin
            prime[l] = BLANK_CHAR[l];
         end else if (sel.char_feed) begin
            prime[l] = prog_s[l];
         end else if (sel.parallel) begin
            prime[l] = aux_s[l];
         end else begin
            prime[l] = ser_s[l];
         end
      end
   end

   // feed oscillators
   tps_cnt_t feed_cnt, next_feed_cnt, fast_cnt, next_fast_cnt;
   logic feed_pulse, fast_pulse;

   always_comb begin
      feed_pulse = 1'b0;
      fast_pulse = 1'b0;
      next_feed_cnt = '0;
      next_fast_cnt = '0;
      if (ready && (sw_latch[`TPS_SW_BLANK] || sw_latch[`TPS_SW_CHAR])) begin
         feed_pulse = (feed_cnt == tps_cnt_t'(FEED_CYC - 1));
         next_feed_cnt = feed_pulse ? '0 : feed_cnt + 1'b1;
      end
      if (ready && sw_latch[`TPS_SW_FAST]) begin
         fast_pulse = (fast_cnt == tps_cnt_t'(FAST_CYC - 1));
         next_fast_cnt = fast_pulse ? '0 : fast_cnt + 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         feed_cnt <= '0;
         fast_cnt <= '0;
      end else begin
         feed_cnt <= next_feed_cnt;
         fast_cnt <= next_fast_cnt;
      end
   end

   // punch command queue
   logic q_valid, q_ready, out_valid, out_ready;
   tps_char_t q_data, out_data;

   always_comb begin
      q_valid = 1'b1;
      q_data = prime;
      if (del_req) begin
         q_data = `TPS_DELETE_CHAR;
      end else if (ready && sel.parallel && aux_fall) begin
         q_data = prime;
      end else if (ready && sel.serial && ser_fall) begin
         q_data = prime;
      end else if (feed_pulse || fast_pulse) begin
         q_data = prime;
      end else begin
         q_valid = 1'b0;
      end
   end

   tps_fifo #(
      .WIDTH(`TPS_LEVELS),
      .DEPTH(`TPS_FIFO_DEPTH)
   ) u_fifo (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .in_valid_i(q_valid),
      .in_ready_o(q_ready),
      .in_data_i(q_data),
      .out_valid_o(out_valid),
      .out_ready_i(out_ready),
      .out_data_o(out_data)
   );

   // level drivers and punch timing oscillator
   tps_drv_e drv, next_drv;
   tps_cnt_t drv_cnt, next_drv_cnt;
   tps_char_t drive, next_drive;
   logic feed_hole, next_feed_hole, cmd, next_cmd;

   assign out_ready = (drv == DRV_IDLE);

   always_comb begin
      next_drv = drv;
      next_drv_cnt = '0;
      next_drive = drive;
      next_feed_hole = feed_hole;
      next_cmd = 1'b0;
      case (drv)
         DRV_IDLE: begin
            if (out_valid) begin
               next_drv = DRV_HOLD;
               next_drive = out_data;
               next_feed_hole = 1'b1;
               next_cmd = 1'b1;
            end
         end
         DRV_HOLD: begin
            next_drv_cnt = drv_cnt + 1'b1;
            if (drv_cnt >= DRIVE_CYC - 1'b1) begin
               next_drv = DRV_IDLE;
               next_drive = '0;
               next_feed_hole = 1'b0;
               next_drv_cnt = '0;
            end
         end
         default: begin
            next_drv = DRV_IDLE;
            next_drive = '0;
            next_feed_hole = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         drv <= DRV_IDLE;
         drv_cnt <= '0;
         drive <= '0;
         feed_hole <= 1'b0;
         cmd <= 1'b0;
      end else begin
         drv <= next_drv;
         drv_cnt <= next_drv_cnt;
         drive <= next_drive;
         feed_hole <= next_feed_hole;
         cmd <= next_cmd;
      end
   end

   // registered status and alarm outputs
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sel_o <= '{serial: 1'b1, parallel: 1'b1, blank_feed: 1'b0, char_feed: 1'b0};
         power_ready_o <= 1'b0;
         hold_off_o <= 1'b0;
         stop_sending_o <= 1'b0;
         low_tape_lamp_o <= 1'b0;
         chad_full_lamp_o <= 1'b0;
         tape_absent_alarm_o <= 1'b0;
         tight_tape_alarm_o <= 1'b0;
      end else begin
         sel_o <= sel;
         power_ready_o <= ready;
         hold_off_o <= !q_ready;
         stop_sending_o <= sense_s.supply_exhausted;
         low_tape_lamp_o <= sense_s.low_tape;
         chad_full_lamp_o <= sense_s.chad_full;
         tape_absent_alarm_o <= sense_s.tape_absent;
         tight_tape_alarm_o <= sense_s.tight_tape;
      end
   end

   assign level_drive_o = drive;
   assign feed_drive_o = feed_hole;
   assign punch_cmd_o = cmd;
endmodule

`default_nettype wire

/* File: bench/tps_sequencer_props.sv */
// port assertions for the punch source sequencer
// assumes it is bound into tps_sequencer with the same stage parameters
`timescale 1ns/100ps
`default_nettype none
module tps_sequencer_chk #(
   parameter int STAGE1_CYC = 20,
   parameter int STAGE2_CYC = 20
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // watched inputs
   input wire logic aux_sample_i,
   input wire tps_pkg::tps_sense_s sense_i,
   // watched outputs
   input wire tps_pkg::tps_char_t level_drive_o,
   input wire logic feed_drive_o,
   input wire logic punch_cmd_o,
   input wire tps_pkg::tps_sel_s sel_o,
   input wire logic power_ready_o,
   input wire logic stop_sending_o,
   input wire logic low_tape_lamp_o
);
   import tps_pkg::*;
   int up_cnt;
   // cycles since reset release, saturating
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         up_cnt <= 0;
      end else if (up_cnt < 100000) begin
         up_cnt <= up_cnt + 1;
      end
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);
   a_src_exclusive: assert property (power_ready_o |-> !(sel_o.serial && sel_o.parallel))
      else $error("serial and parallel selects both active");
   a_prewarm_quiet: assert property (!power_ready_o |-> sel_o == 4'hC && level_drive_o == 8'h00)
      else $error("selects or drivers wrong before ready");
   a_ready_delay: assert property (power_ready_o |-> up_cnt >= STAGE1_CYC + STAGE2_CYC - 2)
      else $error("power ready came too early");
   a_ready_delete: assert property ($rose(power_ready_o) |-> ##[1:6] (punch_cmd_o && level_drive_o == 8'hFF))
      else $error("no delete character after ready");
   a_drive_clear: assert property (punch_cmd_o |-> ##[195:205] (!feed_drive_o || punch_cmd_o))
      else $error("drivers not cleared after a punch");
   a_charfeed_mute: assert property (sel_o.char_feed |-> !sel_o.serial && !sel_o.parallel)
      else $error("source select active during character feed");
   a_par_select: assert property ($rose(aux_sample_i) && power_ready_o && !sel_o.char_feed
      |-> ##[2:5] (sel_o.parallel && !sel_o.serial))
      else $error("sample rise did not select parallel");
   a_par_punch: assert property ($fell(aux_sample_i) && power_ready_o && !feed_drive_o
      && !sel_o.char_feed |-> ##[3:6] punch_cmd_o)
      else $error("sample fall gave no punch");
   a_stop_follow: assert property ($rose(sense_i.supply_exhausted) |-> ##3 stop_sending_o)
      else $error("stop sending did not follow the sensor");
   a_lamp_only: assert property ($rose(sense_i.low_tape) && !sense_i.supply_exhausted
      |-> ##3 (low_tape_lamp_o && !stop_sending_o))
      else $error("low tape sensor handled wrongly");
endmodule
bind tps_sequencer tps_sequencer_chk #(.STAGE1_CYC(STAGE1_CYC), .STAGE2_CYC(STAGE2_CYC))
   u_tps_sequencer_chk (.mclk_i(mclk_i), .nrst_i(nrst_i), .aux_sample_i(aux_sample_i),
   .sense_i(sense_i), .level_drive_o(level_drive_o), .feed_drive_o(feed_drive_o),
   .punch_cmd_o(punch_cmd_o), .sel_o(sel_o), .power_ready_o(power_ready_o),
   .stop_sending_o(stop_sending_o), .low_tape_lamp_o(low_tape_lamp_o));
`default_nettype wire

/* File: bench/tps_sender_model.sv */
// behavioural sending equipment on the parallel link
// assumes the testbench calls send from its own sequence
`timescale 1ns/100ps
`default_nettype none
module tps_sender_model (
   // clock
   input wire logic mclk_i,
   // parallel link
   output var tps_pkg::tps_char_t aux_bits_o,
   output var logic aux_sample_o
);
   import tps_pkg::*;
   initial begin
      aux_bits_o = 8'h00;
      aux_sample_o = 1'b0;
   end
   // one pulse per character, bits released inverted
   task automatic send(input tps_char_t c, input int hi);
      @(posedge mclk_i);
      aux_bits_o <= c;
      aux_sample_o <= 1'b1;
      repeat (hi) @(posedge mclk_i);
      aux_sample_o <= 1'b0;
      repeat (3) @(posedge mclk_i);
      aux_bits_o <= ~c;
   endtask
endmodule
`default_nettype wire

/* File: bench/tb_tps_sequencer.sv */
// self-checking bench for the punch source sequencer
// assumes the sender model and bound checker are compiled alongside
`timescale 1ns/100ps
`default_nettype none
`include "tps_consts.svh"
module tb_tps_sequencer;
   import tps_pkg::*;
   localparam int S1 = 20;
   localparam int S2 = 20;
   localparam int FEED = 300;
   localparam int FAST = 250;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   tps_char_t aux_bits, drive;
   tps_char_t prog = 8'h81;
   tps_char_t ser_bits = 8'h00;
   logic aux_smp, cmd, ready, hold_off, feed;
   logic ser_smp = 1'b0;
   logic [`TPS_NUM_SW-1:0] sw_make = '0;
   logic [`TPS_NUM_SW-1:0] sw_break = '1;
   tps_sense_s sense = '0;
   tps_sel_s sel;
   wire [4:0] alarm;
   int err_count = 0;
   int total_checks = 0;
   int pcount = 0;
   always #5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) if (cmd === 1'b1) pcount++;
   tps_sequencer #(.STAGE1_CYC(S1), .STAGE2_CYC(S2), .FEED_CYC(FEED), .FAST_CYC(FAST))
      u_tps_sequencer (.mclk_i(mclk_i), .nrst_i(nrst_i), .aux_bits_i(aux_bits),
      .aux_sample_i(aux_smp), .serial_bits_i(ser_bits), .serial_sample_i(ser_smp),
      .prog_char_i(prog), .sw_make_i(sw_make), .sw_break_i(sw_break), .sense_i(sense),
      .level_drive_o(drive), .feed_drive_o(feed), .punch_cmd_o(cmd), .sel_o(sel),
      .power_ready_o(ready), .hold_off_o(hold_off), .stop_sending_o(alarm[4]),
      .low_tape_lamp_o(alarm[3]), .chad_full_lamp_o(alarm[2]),
      .tape_absent_alarm_o(alarm[1]), .tight_tape_alarm_o(alarm[0]));
   tps_sender_model u_tps_sender_model (.mclk_i(mclk_i), .aux_bits_o(aux_bits),
      .aux_sample_o(aux_smp));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic wait_cmd(input string what, input logic [31:0] exp, output int n);
      n = 0;
      @(posedge mclk_i);
      #1;
      while (cmd !== 1'b1 && n < 2000) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      chk("punch_cmd_o", 1, cmd);
      chk("feed_drive_o", 1, feed);
      chk(what, exp, drive);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic t_reset;
      int n;
      @(posedge mclk_i);
      nrst_i <= 1'b0;
      repeat (20) @(posedge mclk_i);
      #1;
      chk("sel_o", 8'hC, sel);
      chk("power_ready_o", 0, ready);
      chk("level_drive_o", 0, drive);
      @(posedge mclk_i);
      nrst_i <= 1'b1;
      wait_cmd("delete", 8'hFF, n);
      chk("ready delay", 1, n >= S1 + S2);
      chk("power_ready_o", 1, ready);
      $display("test reset done");
   endtask
   task automatic t_parallel;
      int n;
      tps_char_t c;
      for (int i = 0; i < 2; i++) begin
         c = i ? 8'h5A : 8'hA5;
         u_tps_sender_model.send(c, 4);
         wait_cmd("aux char", c, n);
         chk("sel_o", 8'h4, sel);
      end
      $display("test parallel done");
   endtask
   task automatic t_serial;
      int n;
      @(posedge mclk_i);
      ser_bits <= 8'h3C;
      ser_smp <= 1'b1;
      repeat (6) @(posedge mclk_i);
      #1;
      chk("sel_o", 8'h8, sel);
      @(posedge mclk_i);
      ser_smp <= 1'b0;
      wait_cmd("serial char", 8'h3C, n);
      @(posedge mclk_i);
      ser_bits <= 8'hC3;
      $display("test serial done");
   endtask
   task automatic t_feed;
      int n;
      for (int i = 0; i < `TPS_NUM_SW; i++) begin
         @(posedge mclk_i);
         sw_make[i] <= 1'b1;
         sw_break[i] <= 1'b0;
         repeat (4) @(posedge mclk_i);
         // bounce: neither contact closed
         sw_make[i] <= 1'b0;
         wait_cmd("feed char", (i == 0) ? `TPS_BLANK_CHAR : prog, n);
         wait_cmd("feed char", (i == 0) ? `TPS_BLANK_CHAR : prog, n);
         chk("feed gap", (i == 2) ? FAST : FEED, n + 1);
         chk("feed sel", (i == 0) ? 2 : 1, sel[1:0]);
         @(posedge mclk_i);
         sw_break[i] <= 1'b1;
         repeat (400) @(posedge mclk_i);
         #1;
         chk("feed sel", 0, sel[1:0]);
      end
      $display("test feed done");
   endtask
   task automatic t_sense;
      int p0;
      p0 = pcount;
      for (int i = 0; i < 5; i++) begin
         @(posedge mclk_i);
         sense <= 5'h1 << i;
         repeat (5) @(posedge mclk_i);
         #1;
         chk("alarms", 1 << i, alarm);
      end
      @(posedge mclk_i);
      sense <= '0;
      chk("punches", p0, pcount);
      $display("test sense done");
   endtask
   task automatic t_fifo;
      int p0;
      logic seen = 1'b0;
      p0 = pcount;
      for (int i = 0; i < 20; i++) begin
         u_tps_sender_model.send(8'h10 + i[7:0], 2);
         seen |= (hold_off === 1'b1);
      end
      chk("hold_off_o", 1, seen);
      repeat (3800) @(posedge mclk_i);
      #1;
      chk("hold_off_o", 0, hold_off);
      chk("feed_drive_o", 0, feed);
      chk("level_drive_o", 0, drive);
      chk("punches", 17, pcount - p0);
      $display("test fifo done");
   endtask
   initial begin
      t_reset();
      t_parallel();
      t_serial();
      t_feed();
      t_sense();
      t_fifo();
      t_reset();
      finish_test();
   end
   initial begin
      #500000;
      err_count++;
      finish_test();
   end
endmodule
`default_nettype wire
